/* File: host_model.sv */
`timescale 1ns/100ps
module host_model (
	input  wire logic        mclk,
	output logic             reg_wr_en,
	output logic             reg_rd_en,
	output logic [6:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rd_valid
);
	initial begin
		reg_wr_en = 0;
		reg_rd_en = 0;
		reg_addr = 7'h00;
		reg_wdata = 32'h00000000;
	end
	// Idle lines show inverted values so a stale word is never taken for a fresh one.
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr_en <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr_en <= 0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic v, output logic [31:0] d);
		@(posedge mclk);
		reg_rd_en <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd_en <= 0;
		reg_addr <= ~a;
		#1;
		v = reg_rd_valid;
		d = reg_rdata;
	endtask
endmodule

/* File: tb_velocity_mode_select.sv */
`timescale 1ns/100ps
module tb_velocity_mode_select;
	logic mclk = 0, rst_n = 0, microstep_pulse = 0, step_dir_mode = 0, direct_mode = 0, small_hysteresis = 0;
	logic load_current_cfg = 1, stall_detect_cfg = 1, pwm_chopper_cfg = 1, load_step_cfg = 0;
	logic high_speed_chopper = 1, high_speed_fullstep = 1, chopper_mode_cfg = 0, chopper_sync_mode_cfg = 1;
	logic [3:0] fast_decay_time_cfg = 4'ha, fast_decay_time;
	logic [4:0] standstill_current_scale = 5'h1f;
	logic [8:0] seq_coil_a = 9'h011, seq_coil_b = 9'h1f0, coil_a_current, coil_b_current;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, v;
	logic [6:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic load_current_en, stall_detect_en, pwm_chopper_en, pwm_auto_reg_en, auto_scale_en, load_step_en;
	logic chopper_mode, chopper_sync_mode, fullstep_en;
	int num_errors = 0, checked = 0, per = 0, cnt = 0, cyc = 0;
	velocity_mode_select dut_u (.*);
	host_model host_u (.*);
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// A pulse every per cycles gives a measure of per minus one.
	always @(posedge mclk) begin
		if (per != 0 && cnt >= per - 1) begin
			microstep_pulse <= 1;
			cnt <= 0;
		end else begin
			microstep_pulse <= 0;
			cnt <= cnt + 1;
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task chk(string n, logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task run(int p, int n);
		per = p;
		repeat (n * p) @(posedge mclk);
		#1;
	endtask
	task settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task test_regs();
		host_u.wr(7'h14, 32'd200);
		host_u.wr(7'h15, 32'd50);
		host_u.rd(7'h14, v, rd);
		chk("rd_valid", v, 1);
		chk("low_thr_read", rd, 0);
		host_u.rd(7'h12, v, rd);
		chk("idle_measure", rd, 32'h000fffff);
		host_u.rd(7'h7f, v, rd);
		chk("unmapped_read", rd, 0);
		$display("test regs done");
	endtask
	task test_direct();
		@(posedge mclk);
		direct_mode <= 1;
		load_step_cfg <= 1;
		host_u.wr(7'h2d, 32'h00c8019c);
		settle();
		chk("coil_a", coil_a_current, 9'h19c);
		chk("coil_b", coil_b_current, 9'h0c8);
		chk("load_step_en", load_step_en, 0);
		chk("auto_scale_en", auto_scale_en, 0);
		chk("load_current_en", load_current_en, 0);
		chk("direct_auto_reg", pwm_auto_reg_en, 0);
		host_u.rd(7'h2d, v, rd);
		chk("direct_read", rd, 32'h00c8019c);
		@(posedge mclk);
		standstill_current_scale <= 5'h0f;
		settle();
		chk("coil_a_half", coil_a_current, 9'h1ce);
		chk("coil_b_half", coil_b_current, 9'h064);
		@(posedge mclk);
		step_dir_mode <= 1;
		settle();
		chk("coil_a_stepdir", coil_a_current, 9'h011);
		@(posedge mclk);
		direct_mode <= 0;
		step_dir_mode <= 0;
		load_step_cfg <= 0;
		settle();
		chk("coil_b_seq", coil_b_current, 9'h1f0);
		chk("auto_scale_on", auto_scale_en, 1);
		$display("test direct done");
	endtask
	task test_bands();
		// The first pulse reports the time since reset, so let it outgrow the fast band first.
		repeat (60) @(posedge mclk);
		#1;
		run(100, 5);
		chk("mid_load", load_current_en, 1);
		chk("mid_pwm", pwm_chopper_en, 0);
		chk("mid_stall", stall_detect_en, 1);
		chk("mid_sync", chopper_sync_mode, 1);
		run(48, 5);
		chk("edge_fullstep", fullstep_en, 0);
		run(47, 5);
		chk("fast_fullstep", fullstep_en, 1);
		chk("fast_mode", chopper_mode, 1);
		chk("fast_decay", fast_decay_time, 4'h0);
		chk("fast_sync", chopper_sync_mode, 0);
		chk("fast_load", load_current_en, 0);
		chk("fast_pwm", pwm_chopper_en, 0);
		chk("fast_stall", stall_detect_en, 0);
		run(400, 4);
		chk("slow_stall", stall_detect_en, 0);
		chk("slow_load", load_current_en, 0);
		chk("slow_pwm", pwm_chopper_en, 1);
		chk("slow_auto_reg", pwm_auto_reg_en, 1);
		chk("slow_mode", chopper_mode, 0);
		chk("slow_decay", fast_decay_time, 4'ha);
		$display("test bands done");
	endtask
	task test_small_hyst();
		@(posedge mclk);
		small_hysteresis <= 1;
		run(49, 5);
		chk("small_hyst_fullstep", fullstep_en, 1);
		$display("test small hysteresis done");
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		test_regs();
		test_direct();
		test_bands();
		test_small_hyst();
		finish_test();
	end
endmodule

/* File: thr_cmp_if.sv */
`timescale 1ns/100ps
interface thr_cmp_if;
	logic [vmode_pkg::MEASURE_W-1:0] threshold;
	logic [vmode_pkg::MEASURE_W-1:0] measure;
	logic                            small_hyst;
	logic                            update;
	logic                            fast;

	modport cmp (
		input  threshold,
		input  measure,
		input  small_hyst,
		input  update,
		output fast
	);
	modport ctl (
		output threshold,
		output measure,
		output small_hyst,
		output update,
		input  fast
	);
endinterface

/* File: thr_compare.sv */
`timescale 1ns/100ps
module thr_compare (
	input  wire logic mclk,
	input  wire logic rst_n,
	thr_cmp_if.cmp    bus
);
	logic [vmode_pkg::MEASURE_W:0]   second_val;
	logic [vmode_pkg::MEASURE_W-1:0] hyst_part;
	logic                            fast_r;

	always_comb begin
		if (bus.small_hyst) begin
			hyst_part = bus.threshold >> vmode_pkg::HYST_SHIFT_SMALL;
		end else begin
			hyst_part = bus.threshold >> vmode_pkg::HYST_SHIFT_NORMAL;
		end
		second_val = {1'b0, bus.threshold} - {1'b0, hyst_part} - 21'h000001;
	end

	// Entering the fast range needs the lower compare value, leaving it the plain threshold.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fast_r <= 1'b0;
		end else if (bus.update) begin
			if (fast_r) begin
				if (bus.measure > bus.threshold) begin
					fast_r <= 1'b0;
				end
			end else if (!second_val[vmode_pkg::MEASURE_W] &&
				bus.measure <= second_val[vmode_pkg::MEASURE_W-1:0]) begin
				fast_r <= 1'b1;
			end
		end
	end

	assign bus.fast = fast_r;
endmodule

/* File: velocity_mode_select.sv */
`timescale 1ns/100ps
module velocity_mode_select #(
	parameter int unsigned MEASURE_W = vmode_pkg::MEASURE_W,
	parameter int unsigned COIL_W    = vmode_pkg::COIL_W,
	parameter int unsigned SCALE_W   = vmode_pkg::SCALE_W,
	parameter int unsigned TFD_W     = vmode_pkg::TFD_W
) (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          reg_wr_en,
	input  wire logic                          reg_rd_en,
	input  wire logic [vmode_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [vmode_pkg::DATA_W-1:0]  reg_wdata,
	output logic      [vmode_pkg::DATA_W-1:0]  reg_rdata,
	output logic                               reg_rd_valid,
	input  wire logic                          microstep_pulse,
	input  wire logic                          step_dir_mode,
	input  wire logic                          direct_mode,
	input  wire logic                          small_hysteresis,
	input  wire logic                          load_current_cfg,
	input  wire logic                          stall_detect_cfg,
	input  wire logic                          pwm_chopper_cfg,
	input  wire logic                          load_step_cfg,
	input  wire logic                          high_speed_chopper,
	input  wire logic                          high_speed_fullstep,
	input  wire logic                          chopper_mode_cfg,
	input  wire logic [TFD_W-1:0]              fast_decay_time_cfg,
	input  wire logic                          chopper_sync_mode_cfg,
	input  wire logic [SCALE_W-1:0]            standstill_current_scale,
	input  wire logic [COIL_W-1:0]             seq_coil_a,
	input  wire logic [COIL_W-1:0]             seq_coil_b,
	output logic                               load_current_en,
	output logic                               stall_detect_en,
	output logic                               pwm_chopper_en,
	output logic                               pwm_auto_reg_en,
	output logic                               auto_scale_en,
	output logic                               load_step_en,
	output logic                               chopper_mode,
	output logic      [TFD_W-1:0]              fast_decay_time,
	output logic                               chopper_sync_mode,
	output logic                               fullstep_en,
	output logic      [COIL_W-1:0]             coil_a_current,
	output logic      [COIL_W-1:0]             coil_b_current
);
	localparam logic [MEASURE_W-1:0] MEAS_MAX = vmode_pkg::MEASURE_MAX;
	localparam int unsigned PROD_W = COIL_W + SCALE_W + 1;

	logic [MEASURE_W-1:0]             low_thr_r;
	logic [MEASURE_W-1:0]             high_thr_r;
	logic [vmode_pkg::DATA_W-1:0]     direct_coil_r;
	logic [MEASURE_W-1:0]             interval_cnt_r;
	logic [MEASURE_W-1:0]             measure_r;
	logic                             measure_upd_r;
	logic                             high_fast_d_r;
	logic [vmode_pkg::MASK_CNT_W-1:0] mask_cnt_r;
	logic                             stall_active_r;
	logic                             direct_eff;
	logic                             steps_present;
	logic                             low_fast;
	logic                             high_fast;
	logic                             mid_band;
	logic                             load_step_active;
	logic                             stall_masked;
	logic signed [PROD_W-1:0]         prod_a;
	logic signed [PROD_W-1:0]         prod_b;
	logic signed [SCALE_W+1:0]        scale_mul;

	thr_cmp_if low_if ();
	thr_cmp_if high_if ();

	// Register writes from the serial port; the two thresholds are write-only.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			low_thr_r     <= vmode_pkg::LOW_VEL_THR_RST;
			high_thr_r    <= vmode_pkg::HIGH_VEL_THR_RST;
			direct_coil_r <= vmode_pkg::DIRECT_COIL_RST;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				vmode_pkg::ADDR_LOW_VEL_THR: begin
					low_thr_r <= reg_wdata[MEASURE_W-1:0];
				end
				vmode_pkg::ADDR_HIGH_VEL_THR: begin
					high_thr_r <= reg_wdata[MEASURE_W-1:0];
				end
				vmode_pkg::ADDR_DIRECT_COIL_CUR: begin
					direct_coil_r <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Reads answer one cycle later; unmapped and write-only addresses read zero.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata    <= '0;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				unique case (reg_addr)
					vmode_pkg::ADDR_STEP_INTERVAL: begin
						reg_rdata <= {{(vmode_pkg::DATA_W-MEASURE_W){1'b0}}, measure_r};
					end
					vmode_pkg::ADDR_DIRECT_COIL_CUR: begin
						reg_rdata <= direct_coil_r;
					end
					default: begin
						reg_rdata <= '0;
					end
				endcase
			end
		end
	end

	// Interval between 1/256 microstep events in clocks, independent of resolution.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			interval_cnt_r <= '0;
			measure_r      <= MEAS_MAX;
			measure_upd_r  <= 1'b0;
		end else begin
			measure_upd_r <= 1'b0;
			if (microstep_pulse) begin
				interval_cnt_r <= '0;
				measure_r      <= interval_cnt_r;
				measure_upd_r  <= 1'b1;
			end else if (interval_cnt_r != MEAS_MAX) begin
				interval_cnt_r <= interval_cnt_r + 20'h00001;
				if (interval_cnt_r > measure_r && measure_r != MEAS_MAX) begin
					// A slowing motor must not wait for the next step to be seen as slow.
					measure_r     <= interval_cnt_r;
					measure_upd_r <= 1'b1;
				end
			end else if (measure_r != MEAS_MAX) begin
				measure_r     <= MEAS_MAX;
				measure_upd_r <= 1'b1;
			end
		end
	end

	assign low_if.threshold   = low_thr_r;
	assign low_if.measure     = measure_r;
	assign low_if.small_hyst  = small_hysteresis;
	assign low_if.update      = measure_upd_r;
	assign high_if.threshold  = high_thr_r;
	assign high_if.measure    = measure_r;
	assign high_if.small_hyst = small_hysteresis;
	assign high_if.update     = measure_upd_r;

	thr_compare u_low_cmp (
		.mclk  (mclk),
		.rst_n (rst_n),
		.bus   (low_if)
	);

	thr_compare u_high_cmp (
		.mclk  (mclk),
		.rst_n (rst_n),
		.bus   (high_if)
	);

	assign low_fast  = low_if.fast;
	assign high_fast = high_if.fast;
	assign mid_band  = low_fast && !high_fast;

	assign direct_eff       = direct_mode && !step_dir_mode;
	assign steps_present    = measure_r != MEAS_MAX;
	assign load_step_active = load_step_cfg && !direct_eff;

	// Mask window counts microsteps so its length tracks electrical periods at any speed.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			high_fast_d_r <= 1'b0;
			mask_cnt_r    <= '0;
		end else begin
			high_fast_d_r <= high_fast;
			if (high_fast != high_fast_d_r) begin
				mask_cnt_r <= vmode_pkg::STALL_MASK_STEPS;
			end else if (microstep_pulse && mask_cnt_r != '0) begin
				mask_cnt_r <= mask_cnt_r - 12'h001;
			end
		end
	end

	assign stall_masked = mask_cnt_r != '0;

	// In load-dependent stepping the detector stays on once the low threshold was reached.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stall_active_r <= 1'b0;
		end else if (low_fast) begin
			stall_active_r <= 1'b1;
		end else if (!load_step_active) begin
			stall_active_r <= 1'b0;
		end
	end

	// Without steps in direct mode there is no load measure, so the load features stay off.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			load_current_en <= 1'b0;
			auto_scale_en   <= 1'b0;
			load_step_en    <= 1'b0;
		end else begin
			load_current_en <= load_current_cfg && mid_band && (!direct_eff || steps_present);
			auto_scale_en   <= !direct_eff || steps_present;
			load_step_en    <= load_step_active;
		end
	end

	// The mask gates the output itself, so a transient at a high threshold crossing is masked from one clock after fullstep and chopper switch.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stall_detect_en <= 1'b0;
		end else begin
			stall_detect_en <= stall_detect_cfg && stall_active_r && !stall_masked &&
				(!direct_eff || steps_present);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwm_chopper_en  <= 1'b0;
			pwm_auto_reg_en <= 1'b0;
		end else begin
			pwm_chopper_en  <= pwm_chopper_cfg && !mid_band && !high_fast;
			pwm_auto_reg_en <= pwm_chopper_cfg && !mid_band && !high_fast && !direct_eff;
		end
	end

	// Both chopper fields switch together, so the driver never sees a mixed setting.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chopper_mode    <= 1'b0;
			fast_decay_time <= '0;
		end else if (high_speed_chopper && high_fast) begin
			chopper_mode    <= 1'b1;
			fast_decay_time <= '0;
		end else begin
			chopper_mode    <= chopper_mode_cfg;
			fast_decay_time <= fast_decay_time_cfg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chopper_sync_mode <= 1'b0;
		end else begin
			chopper_sync_mode <= chopper_sync_mode_cfg && !high_fast;
		end
	end

	// Fullstep follows the comparator directly; the stall mask covers its switch-over.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fullstep_en <= 1'b0;
		end else begin
			fullstep_en <= high_speed_fullstep && high_fast;
		end
	end

	// Scale of n means (n+1)/32 of the written value, so full scale passes it unchanged.
	assign scale_mul = signed'({2'b00, standstill_current_scale} + 7'sh01);
	assign prod_a = PROD_W'(signed'(direct_coil_r[vmode_pkg::COIL_A_LSB +: COIL_W])) * PROD_W'(scale_mul);
	assign prod_b = PROD_W'(signed'(direct_coil_r[vmode_pkg::COIL_B_LSB +: COIL_W])) * PROD_W'(scale_mul);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			coil_a_current <= '0;
			coil_b_current <= '0;
		end else if (direct_eff) begin
			coil_a_current <= prod_a[SCALE_W +: COIL_W];
			coil_b_current <= prod_b[SCALE_W +: COIL_W];
		end else begin
			coil_a_current <= seq_coil_a;
			coil_b_current <= seq_coil_b;
		end
	end

endmodule

/* File: vmode_pkg.sv */
package vmode_pkg;

	localparam int unsigned MEASURE_W = 20;
	localparam int unsigned COIL_W    = 9;
	localparam int unsigned SCALE_W   = 5;
	localparam int unsigned TFD_W     = 4;
	localparam int unsigned ADDR_W    = 7;
	localparam int unsigned DATA_W    = 32;

	localparam logic [ADDR_W-1:0] ADDR_STEP_INTERVAL   = 7'h12;
	localparam logic [ADDR_W-1:0] ADDR_LOW_VEL_THR     = 7'h14;
	localparam logic [ADDR_W-1:0] ADDR_HIGH_VEL_THR    = 7'h15;
	localparam logic [ADDR_W-1:0] ADDR_DIRECT_COIL_CUR = 7'h2d;

	localparam int unsigned COIL_A_LSB = 0;
	localparam int unsigned COIL_B_LSB = 16;

	localparam logic [MEASURE_W-1:0] LOW_VEL_THR_RST  = 20'h00000;
	localparam logic [MEASURE_W-1:0] HIGH_VEL_THR_RST = 20'h00000;
	localparam logic [DATA_W-1:0]    DIRECT_COIL_RST  = 32'h00000000;
	localparam logic [MEASURE_W-1:0] MEASURE_MAX      = 20'hfffff;

	localparam int unsigned HYST_SHIFT_NORMAL = 4;
	localparam int unsigned HYST_SHIFT_SMALL  = 5;

	localparam int unsigned MICROSTEPS_PER_EPERIOD = 1024;
	localparam int unsigned MASK_CNT_W             = 12;
	localparam logic [MASK_CNT_W-1:0] STALL_MASK_STEPS = 12'ha00;

endpackage

/* File: vmode_props.sv */
`timescale 1ns/100ps
module vmode_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        reg_rd_en,
	input wire logic [6:0]  reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rd_valid,
	input wire logic        direct_mode,
	input wire logic        step_dir_mode,
	input wire logic        load_current_cfg,
	input wire logic        stall_detect_cfg,
	input wire logic        high_speed_chopper,
	input wire logic        high_speed_fullstep,
	input wire logic [8:0]  seq_coil_a,
	input wire logic        load_current_en,
	input wire logic        stall_detect_en,
	input wire logic        pwm_chopper_en,
	input wire logic        load_step_en,
	input wire logic        chopper_mode,
	input wire logic [3:0]  fast_decay_time,
	input wire logic        chopper_sync_mode,
	input wire logic        fullstep_en,
	input wire logic [8:0]  coil_a_current
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_measure_read: assert property (reg_rd_en && reg_addr == vmode_pkg::ADDR_STEP_INTERVAL |=>
		reg_rd_valid && reg_rdata[31:20] == 12'h000) else $error("step interval read malformed");
	chk_thr_write_only: assert property (reg_rd_en && (reg_addr == 7'h14 || reg_addr == 7'h15) |=>
		reg_rdata == 32'h00000000) else $error("threshold read not zero");
	chk_mid_band: assert property (load_current_en |-> !pwm_chopper_en && $past(load_current_cfg))
		else $error("load current with pwm chopper");
	chk_stall_config: assert property (stall_detect_en |-> $past(stall_detect_cfg))
		else $error("stall detect unconfigured");
	chk_fast_band: assert property (fullstep_en |-> !load_current_en && !pwm_chopper_en && !chopper_sync_mode)
		else $error("fast band features left on");
	chk_fast_chopper: assert property (fullstep_en && $past(high_speed_chopper) |->
		chopper_mode && fast_decay_time == 4'h0) else $error("fast chopper setting wrong");
	chk_fullstep_cfg: assert property (fullstep_en |-> $past(high_speed_fullstep))
		else $error("fullstep without option");
	chk_stall_mask: assert property ($rose(fullstep_en) |-> ##2 !stall_detect_en [*4])
		else $error("stall not masked at crossing");
	chk_no_load_step: assert property ($past(direct_mode) && !$past(step_dir_mode) |-> !load_step_en)
		else $error("load stepping in direct mode");
	chk_coil_sequencer: assert property (!direct_mode && $stable(seq_coil_a) |=>
		coil_a_current == $past(seq_coil_a)) else $error("coil a not from sequencer");
endmodule
bind velocity_mode_select vmode_props chk_u (.*);
